// file: hw/emoc_top.sv
// Purpose: Event pin masking, interrupt enables, overcurrent capture, voltage level
// Assumes: Register port is synchronous; reads return data one cycle after rd strobe
// Notes:   Event pin is active low and registered
`timescale 1ns/1ps
module emoc_top
  import emoc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  output logic                   reg_rvalid_out,
  input  wire logic [2:0]        zc_timeout_in,
  input  wire logic [NL_W-1:0]   noload_change_in,
  input  wire logic [NL_W-1:0]   noload_state_in,
  input  wire logic              waveform_ready_in,
  input  wire logic [3:0]        energy_pulse_in,
  input  wire logic [3:0]        pulse_negative_in,
  input  wire logic [2:0]        swell_in,
  input  wire logic [2:0]        dip_in,
  input  wire logic [3:0]        overcurrent_en_in,
  input  wire logic              halfcycle_strobe_in,
  input  wire logic [VAL_W-1:0]  phase_a_halfcycle_irms,
  input  wire logic [VAL_W-1:0]  phase_b_halfcycle_irms,
  input  wire logic [VAL_W-1:0]  phase_c_halfcycle_irms,
  input  wire logic [VAL_W-1:0]  neutral_halfcycle_irms,
  output logic                   irq_out,
  output logic                   event_n_out,
  output logic      [VAL_W-1:0]  fund_voltage_level_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [IRQ_EN_W-1:0]   irq_en_reg;
  logic [EVT_MASK_W-1:0] evt_mask_reg;
  logic [VAL_W-1:0]      oc_thr_reg;
  logic [VAL_W-1:0]      volt_lvl_reg;
  logic [3:0]            pulse_prev_reg;
  logic [3:0]            pulse_neg_reg;
  logic                  irq_reg;
  logic                  event_n_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic                  rvalid_reg;
  logic [VAL_W-1:0]      cap_a;
  logic [VAL_W-1:0]      cap_b;
  logic [VAL_W-1:0]      cap_c;
  logic [VAL_W-1:0]      cap_n;

  // Index decode
  wire hit_irq_en   = (reg_addr_in == IRQ_EN_IDX);
  wire hit_mask     = (reg_addr_in == EVT_MASK_IDX);
  wire hit_thr      = (reg_addr_in == OC_THR_IDX);
  wire hit_cap_a    = (reg_addr_in == OC_A_IDX);
  wire hit_cap_b    = (reg_addr_in == OC_B_IDX);
  wire hit_cap_c    = (reg_addr_in == OC_C_IDX);
  wire hit_cap_n    = (reg_addr_in == OC_N_IDX);
  wire hit_volt_lvl = (reg_addr_in == VOLT_LVL_IDX);

  // Write strobes; read-only and unmapped indices have none
  wire wr_irq_en   = reg_wr_in && hit_irq_en;
  wire wr_mask     = reg_wr_in && hit_mask;
  wire wr_thr      = reg_wr_in && hit_thr;
  wire wr_volt_lvl = reg_wr_in && hit_volt_lvl;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_reg   <= '0;
      evt_mask_reg <= '0;
      oc_thr_reg   <= OC_THR_RST;
      volt_lvl_reg <= VOLT_LVL_RST;
    end else begin
      if (wr_irq_en) irq_en_reg <= reg_wdata_in[IRQ_EN_W-1:0];
      if (wr_mask)   evt_mask_reg <= reg_wdata_in[EVT_MASK_W-1:0];
      if (wr_thr)    oc_thr_reg <= reg_wdata_in[VAL_W-1:0];
      if (wr_volt_lvl) volt_lvl_reg <= reg_wdata_in[VAL_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  // Fields padded to a full word; reserved upper bits read zero
  wire [DATA_W-1:0] rd_irq_en   = {{(DATA_W-IRQ_EN_W){1'b0}}, irq_en_reg};
  wire [DATA_W-1:0] rd_mask     = {{(DATA_W-EVT_MASK_W){1'b0}}, evt_mask_reg};
  wire [DATA_W-1:0] rd_thr      = {{RSVD_W{1'b0}}, oc_thr_reg};
  wire [DATA_W-1:0] rd_cap_a    = {{RSVD_W{1'b0}}, cap_a};
  wire [DATA_W-1:0] rd_cap_b    = {{RSVD_W{1'b0}}, cap_b};
  wire [DATA_W-1:0] rd_cap_c    = {{RSVD_W{1'b0}}, cap_c};
  wire [DATA_W-1:0] rd_cap_n    = {{RSVD_W{1'b0}}, cap_n};
  wire [DATA_W-1:0] rd_volt_lvl = {{RSVD_W{1'b0}}, volt_lvl_reg};
  wire [DATA_W-1:0] rd_mux      = hit_irq_en   ? rd_irq_en   :
                                  hit_mask     ? rd_mask     :
                                  hit_thr      ? rd_thr      :
                                  hit_cap_a    ? rd_cap_a    :
                                  hit_cap_b    ? rd_cap_b    :
                                  hit_cap_c    ? rd_cap_c    :
                                  hit_cap_n    ? rd_cap_n    :
                                  hit_volt_lvl ? rd_volt_lvl :
                                  ZERO_WORD;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg  <= ZERO_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= reg_rd_in ? rd_mux : rdata_reg;
      rvalid_reg <= reg_rd_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Negative pulse flags, refreshed at each falling edge of a pulse output
  wire [3:0] pulse_fall = pulse_prev_reg & ~energy_pulse_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_prev_reg <= '0;
      pulse_neg_reg  <= '0;
    end else begin
      pulse_prev_reg <= energy_pulse_in;
      for (int i = 0; i < 4; i++) begin
        if (pulse_fall[i]) pulse_neg_reg[i] <= pulse_negative_in[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event pin and interrupt
  wire [EVT_MASK_W-1:0] evt_cond = {waveform_ready_in, noload_state_in, pulse_neg_reg,
                                    swell_in, dip_in};
  wire evt_any = |(evt_cond & evt_mask_reg);
  wire [IRQ_EN_W-1:0] irq_cond = {zc_timeout_in, noload_change_in};
  wire irq_any = |(irq_cond & irq_en_reg);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      event_n_reg <= 1'b1;
      irq_reg     <= 1'b0;
    end else begin
      event_n_reg <= ~evt_any;
      irq_reg     <= irq_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overcurrent captures
  // Phase A capture
  emoc_capture #(
    .W(VAL_W)
  ) u_cap_a (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .enable_in (overcurrent_en_in[0]),
    .strobe_in (halfcycle_strobe_in),
    .rms_in    (phase_a_halfcycle_irms),
    .limit_in  (oc_thr_reg),
    .value_out (cap_a)
  );

  // Phase B capture
  emoc_capture #(
    .W(VAL_W)
  ) u_cap_b (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .enable_in (overcurrent_en_in[1]),
    .strobe_in (halfcycle_strobe_in),
    .rms_in    (phase_b_halfcycle_irms),
    .limit_in  (oc_thr_reg),
    .value_out (cap_b)
  );

  // Phase C capture
  emoc_capture #(
    .W(VAL_W)
  ) u_cap_c (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .enable_in (overcurrent_en_in[2]),
    .strobe_in (halfcycle_strobe_in),
    .rms_in    (phase_c_halfcycle_irms),
    .limit_in  (oc_thr_reg),
    .value_out (cap_c)
  );

  // Neutral capture
  emoc_capture #(
    .W(VAL_W)
  ) u_cap_n (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .enable_in (overcurrent_en_in[3]),
    .strobe_in (halfcycle_strobe_in),
    .rms_in    (neutral_halfcycle_irms),
    .limit_in  (oc_thr_reg),
    .value_out (cap_n)
  );

  assign reg_rdata_out          = rdata_reg;
  assign reg_rvalid_out         = rvalid_reg;
  assign irq_out                = irq_reg;
  assign event_n_out            = event_n_reg;
  assign fund_voltage_level_out = volt_lvl_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_zc_timeout_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    (|(zc_timeout_in & irq_en_reg[IRQ_EN_W-1:ZXTO_LSB])) |=> irq_out)
    else $error("timeout interrupt missing");
  chk_noload_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    (|(noload_change_in & irq_en_reg[NL_W-1:0])) |=> irq_out)
    else $error("no-load interrupt missing");
  chk_ready_event: assert property (@(posedge clk_in) disable iff (rst_in)
    (waveform_ready_in && evt_mask_reg[EV_READY_BIT]) |=> !event_n_out)
    else $error("ready event missing");
  chk_noload_event: assert property (@(posedge clk_in) disable iff (rst_in)
    (|(noload_state_in & evt_mask_reg[EV_READY_BIT-1:EV_NL_LSB])) |=> !event_n_out)
    else $error("no-load event missing");
  chk_negpulse_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    ($fell(energy_pulse_in[0]) && pulse_negative_in[0] && evt_mask_reg[EV_NEG_LSB])
      |=> ##1 !event_n_out)
    else $error("negative pulse event missing");
  chk_dip_event: assert property (@(posedge clk_in) disable iff (rst_in)
    (|({swell_in, dip_in} & evt_mask_reg[EV_NEG_LSB-1:EV_DIP_LSB])) |=> !event_n_out)
    else $error("dip or swell event missing");
  chk_thr_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_thr |=> oc_thr_reg == $past(reg_wdata_in[VAL_W-1:0]))
    else $error("threshold write lost");
  chk_volt_lvl_out: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_volt_lvl |=> fund_voltage_level_out == $past(reg_wdata_in[VAL_W-1:0]))
    else $error("voltage level write lost");
  chk_event_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !evt_any |=> event_n_out)
    else $error("event pin low without cause");
  chk_read_mask: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == EVT_MASK_IDX) |=> reg_rvalid_out
      && reg_rdata_out[EVT_MASK_W-1:0] == $past(evt_mask_reg))
    else $error("mask readback wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Register port and flag checks
  chk_irq_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !irq_any
      |=> !irq_out)
    else $error("interrupt without enabled cause");

  chk_irq_en_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_irq_en
      |=> irq_en_reg == $past(reg_wdata_in[IRQ_EN_W-1:0]))
    else $error("interrupt enable write lost");

  chk_mask_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_mask
      |=> evt_mask_reg == $past(reg_wdata_in[EVT_MASK_W-1:0]))
    else $error("event mask write lost");

  chk_irq_en_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_irq_en)
      |=> reg_rdata_out == {{(DATA_W-IRQ_EN_W){1'b0}}, $past(irq_en_reg)})
    else $error("interrupt enable readback wrong");

  chk_thr_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_thr)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(oc_thr_reg)})
    else $error("threshold readback wrong");

  chk_cap_a_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_cap_a)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(cap_a)})
    else $error("phase A capture readback wrong");

  chk_cap_b_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_cap_b)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(cap_b)})
    else $error("phase B capture readback wrong");

  chk_cap_c_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_cap_c)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(cap_c)})
    else $error("phase C capture readback wrong");

  chk_cap_n_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_cap_n)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(cap_n)})
    else $error("neutral capture readback wrong");

  chk_volt_lvl_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && hit_volt_lvl)
      |=> reg_rdata_out == {{RSVD_W{1'b0}}, $past(volt_lvl_reg)})
    else $error("voltage level readback wrong");

  chk_swell_event: assert property (@(posedge clk_in) disable iff (rst_in)
    (|(swell_in & evt_mask_reg[EV_NEG_LSB-1:EV_SWELL_LSB]))
      |=> !event_n_out)
    else $error("swell event missing");

  chk_negpulse_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !(|pulse_fall)
      |=> $stable(pulse_neg_reg))
    else $error("negative pulse flag changed without a falling edge");
endmodule

// file: hw/emoc_pkg.sv
// Purpose: Constants for the event mask and overcurrent capture block
// Assumes: 32-bit register words reached by index through a simple register port
// Notes:   Offsets are word indices on the register port
//
// Summary of operation
// - Interrupt enable bits 8, 7 and 6 raise an interrupt on a zero-crossing timeout of phase C, B, A.
// - Interrupt enable bits 5 to 0 raise an interrupt when any phase of that energy enters or leaves no load.
// - Event mask bit 16 pulls the event pin low when new waveform samples are ready.
// - Event mask bits 15 to 10 pull the event pin low when any phase of that energy is in no load.
// - Event mask bits 9 to 6 pull the event pin low if the last pulse on output 4..1 was negative, sampled at its falling edge.
// - Event mask bits 5 to 3 flag swell on phase C, B, A and bits 2 to 0 flag dip on phase C, B, A.
// - The overcurrent threshold is a 24-bit read/write field resetting to all ones, upper byte reads zero.
// - Each phase capture takes its half-cycle rms on the half-cycle strobe when its enable is set and the rms exceeds the threshold.
// - The neutral capture takes the neutral half-cycle rms under the same condition with its own enable.
// - The voltage level is a 24-bit read/write value with a fixed reset default used by fundamental math.
// - All interrupt enable and event mask bits reset to zero and are readable and writable.
package emoc_pkg;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          VAL_W        = 24;
  localparam logic [11:0] IRQ_EN_IDX   = 12'h405;
  localparam logic [11:0] EVT_MASK_IDX = 12'h407;
  localparam logic [11:0] OC_THR_IDX   = 12'h409;
  localparam logic [11:0] OC_A_IDX     = 12'h40a;
  localparam logic [11:0] OC_B_IDX     = 12'h40b;
  localparam logic [11:0] OC_C_IDX     = 12'h40c;
  localparam logic [11:0] OC_N_IDX     = 12'h40d;
  localparam logic [11:0] VOLT_LVL_IDX = 12'h40f;
  localparam int          IRQ_EN_W     = 9;
  localparam int          EVT_MASK_W   = 17;
  localparam logic [23:0] OC_THR_RST   = 24'hffffff;
  localparam logic [23:0] VOLT_LVL_RST = 24'h045d45;
  localparam int          RSVD_W       = DATA_W - VAL_W;
  localparam logic [23:0] CAP_RST      = 24'h000000;
  localparam logic [31:0] ZERO_WORD    = 32'h00000000;
  localparam int          ZXTO_LSB     = 6;
  localparam int          NL_W         = 6;
  localparam int          EV_DIP_LSB   = 0;
  localparam int          EV_SWELL_LSB = 3;
  localparam int          EV_NEG_LSB   = 6;
  localparam int          EV_NL_LSB    = 10;
  localparam int          EV_READY_BIT = 16;
endpackage

// file: hw/emoc_capture.sv
// Purpose: One overcurrent capture register
// Assumes: rms value valid while its strobe is high
// Notes:   Holds the last value that exceeded the threshold while enable_in and strobe_in were both high
`timescale 1ns/1ps
module emoc_capture
  import emoc_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         enable_in,
  input  wire logic         strobe_in,
  input  wire logic [W-1:0] rms_in,
  input  wire logic [W-1:0] limit_in,
  output logic      [W-1:0] value_out
);
  logic [W-1:0] value_reg;
  wire          take = enable_in && strobe_in && (rms_in > limit_in);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_reg <= W'(CAP_RST);
    end else if (take) begin
      value_reg <= rms_in;
    end
  end
  assign value_out = value_reg;

  chk_capture_takes_rms: assert property (@(posedge clk_in) disable iff (rst_in)
    take |=> value_out == $past(rms_in))
    else $error("capture did not take rms");
  chk_capture_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    !take |=> $stable(value_out))
    else $error("capture changed without cause");
endmodule

// file: tb/emoc_meter.sv
// Purpose: Energy pulse source facing emoc_top
// Assumes: fire_in is a one-cycle request from the bench
// Notes:   Sign line is wrong while a pulse is high, right as it falls, and toggles every cycle once idle
`timescale 1ns/1ps
module emoc_meter (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] fire_in,
  input  wire logic [3:0] sign_in,
  output logic      [3:0] energy_pulse_out,
  output logic      [3:0] pulse_negative_out
);
  logic [1:0] cnt_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      energy_pulse_out   <= 4'h0;
      pulse_negative_out <= 4'h0;
      cnt_reg            <= 2'h0;
    end else if (|fire_in) begin
      energy_pulse_out   <= fire_in;
      pulse_negative_out <= ~sign_in;
      cnt_reg            <= 2'h3;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
      if (cnt_reg == 2'h2) begin
        energy_pulse_out   <= 4'h0;
        pulse_negative_out <= sign_in;
      end
    end else begin
      pulse_negative_out <= ~pulse_negative_out;
    end
  end
endmodule

// file: tb/tb.sv
// Purpose: Register and event pin checks for emoc_top
// Assumes: emoc_meter supplies the energy pulses
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module tb
  import emoc_pkg::*;
;
  logic        clk_in, rst_in, wr, rd, wfr, stb, rvalid, irq, ev_n;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0]  zc, swell, dip;
  logic [5:0]  nlc, nls;
  logic [3:0]  pulse, neg, fire, sign, oc_en;
  logic [23:0] ia, ib, ic, in_rms, vlev;
  int          n_fail, n_tests, i;

  emoc_top dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .zc_timeout_in(zc), .noload_change_in(nlc), .noload_state_in(nls),
    .waveform_ready_in(wfr), .energy_pulse_in(pulse), .pulse_negative_in(neg),
    .swell_in(swell), .dip_in(dip), .overcurrent_en_in(oc_en), .halfcycle_strobe_in(stb),
    .phase_a_halfcycle_irms(ia), .phase_b_halfcycle_irms(ib), .phase_c_halfcycle_irms(ic),
    .neutral_halfcycle_irms(in_rms), .irq_out(irq), .event_n_out(ev_n),
    .fund_voltage_level_out(vlev));
  emoc_meter meter (.clk_in(clk_in), .rst_in(rst_in), .fire_in(fire), .sign_in(sign),
    .energy_pulse_out(pulse), .pulse_negative_out(neg));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    int k;
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    k = 0;
    #1;
    while (rvalid !== 1'b1 && k < 4) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k == 4) begin
      n_fail++;
      finish_test();
    end else begin
      chk(rdata, exp);
    end
  endtask

  task automatic set_cond(input logic [16:0] c);
    @(posedge clk_in);
    {wfr, nls, sign, swell, dip} <= c;
    fire <= 4'hf;
    @(posedge clk_in);
    fire <= 4'h0;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {wr, rd, wfr, stb, zc, nlc, nls, swell, dip, fire, sign, oc_en} = '0;
    {addr, wdata, ia, ib, ic, in_rms, n_fail, n_tests} = '0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk({8'h00, vlev}, 32'h00045d45);
    chk({31'h0, ev_n}, 32'h1);
    rd_reg(IRQ_EN_IDX, 32'h0);
    rd_reg(EVT_MASK_IDX, 32'h0);
    rd_reg(OC_THR_IDX, 32'h00ffffff);
    for (i = 0; i < 4; i++) rd_reg(12'(OC_A_IDX + i), 32'h0);
    rd_reg(VOLT_LVL_IDX, 32'h00045d45);
    rd_reg(12'h40e, 32'h0);
    @(posedge clk_in);
    {zc, nlc} <= 9'h1ff;
    set_cond(17'h1ffff);
    settle();
    chk({31'h0, ev_n}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    set_cond(17'h0);
    wr_reg(IRQ_EN_IDX, 32'hffffffff);
    rd_reg(IRQ_EN_IDX, 32'h000001ff);
    wr_reg(EVT_MASK_IDX, 32'hffffffff);
    rd_reg(EVT_MASK_IDX, 32'h0001ffff);
    wr_reg(OC_THR_IDX, 32'h12345678);
    rd_reg(OC_THR_IDX, 32'h00345678);
    wr_reg(VOLT_LVL_IDX, 32'habcdef12);
    rd_reg(VOLT_LVL_IDX, 32'h00cdef12);
    chk({8'h00, vlev}, 32'h00cdef12);
    wr_reg(OC_A_IDX, 32'hffffffff);
    rd_reg(OC_A_IDX, 32'h0);
    for (i = 0; i < 17; i++) begin
      wr_reg(EVT_MASK_IDX, 32'h1 << i);
      set_cond(17'h1 << i);
      settle();
      chk({31'h0, ev_n}, 32'h0);
      set_cond(17'h0);
      settle();
      chk({31'h0, ev_n}, 32'h1);
    end
    for (i = 0; i < 9; i++) begin
      wr_reg(IRQ_EN_IDX, 32'h1 << i);
      @(posedge clk_in);
      {zc, nlc} <= 9'h1 << i;
      settle();
      chk({31'h0, irq}, 32'h1);
      @(posedge clk_in);
      {zc, nlc} <= 9'h1ff ^ (9'h1 << i);
      settle();
      chk({31'h0, irq}, 32'h0);
    end
    wr_reg(OC_THR_IDX, 32'h00000100);
    @(posedge clk_in);
    {ia, ib, ic, in_rms} <= {24'h101, 24'h100, 24'h0ff, 24'h200};
    {oc_en, stb} <= 5'hf;
    @(posedge clk_in);
    stb <= 1'b0;
    rd_reg(OC_A_IDX, 32'h101);
    rd_reg(OC_B_IDX, 32'h0);
    rd_reg(OC_C_IDX, 32'h0);
    rd_reg(OC_N_IDX, 32'h0);
    @(posedge clk_in);
    {oc_en, stb, ia} <= {4'h8, 1'b1, 24'h300};
    @(posedge clk_in);
    stb <= 1'b0;
    rd_reg(OC_N_IDX, 32'h200);
    rd_reg(OC_A_IDX, 32'h101);
    finish_test();
  end
endmodule
